// ==== rtl/mic_pkg.sv ====
// constants of the maskable interrupt controller
package mic_pkg;
   localparam int unsigned NumSrc        = 24;
   localparam int unsigned LevelW        = 2;
   localparam int unsigned DepthMax      = 4;
   localparam int unsigned EntryCycles   = 14;
   localparam int unsigned EntryCyclesX  = 17;
   localparam int unsigned ReturnCycles  = 12;
   localparam int unsigned ReturnCyclesX = 14;
   localparam int unsigned CntW          = 5;
   localparam logic [LevelW-1:0] LevelLow  = 2'h0;
   localparam logic [LevelW-1:0] LevelMid  = 2'h1;
   localparam logic [LevelW-1:0] LevelHigh = 2'h2;
   // no handler in service: every level is above it
   localparam logic [LevelW-1:0] LevelIdle = 2'h3;
   // entry step boundaries, counted from the first entry cycle (StepSavePsw from the pc save)
   localparam logic [CntW-1:0] StepSaveCsr  = 5'h0;
   localparam logic [CntW-1:0] StepSavePsw  = 5'h6;
   localparam logic [CntW-1:0] StepClearReq = 5'h8;
   // vector table in source index order (ascending address)
   localparam logic [15:0] VecTable [NumSrc] = '{
      16'h000A, 16'h000C, 16'h0016, 16'h0018, 16'h001A, 16'h001C,
      16'h001E, 16'h0020, 16'h0026, 16'h0028, 16'h002A, 16'h002C,
      16'h0036, 16'h0038, 16'h003A, 16'h003E, 16'h0042, 16'h0044,
      16'h0048, 16'h006A, 16'h006C, 16'h006E, 16'h0070, 16'h0072};
   // source indices
   localparam int unsigned SrcExt0 = 0;
   localparam int unsigned SrcFrc  = 1;
   localparam int unsigned SrcTm9  = 23;
   typedef enum logic [1:0] {
      MIC_IDLE,
      MIC_ENTRY,
      MIC_RETURN
   } mic_state_e;
endpackage : mic_pkg

// ==== rtl/mic_irq_ctrl.sv ====
// maskable interrupt controller: request latching, arbitration, entry and return
`timescale 1ns/100ps
`default_nettype none
module mic_irq_ctrl (
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire logic [23:0]            srcEvent,
   input  wire logic [23:0]            source_enable,
   input  wire logic [47:0]            priority_level_code,
   input  wire logic                   priority_ctrl_on,
   input  wire logic                   expandedSpace,
   input  wire logic                   reqWrEn,
   input  wire logic [23:0]            reqWrData,
   input  wire logic                   mieWrEn,
   input  wire logic                   mieWrData,
   input  wire logic                   instrBoundary,
   input  wire logic                   return_from_irq_instr,
   output logic      [23:0]            reqFlags,
   output logic                        master_irq_enable,
   output logic                        entryBusy,
   output logic                        returnBusy,
   output logic      [2:0]             saveStep,
   output logic                        saveStrobe,
   output logic                        restoreStrobe,
   output logic      [2:0]             restoreStep,
   output logic                        pcLoad,
   output logic      [15:0]            pcVector,
   output logic      [1:0]             inServiceLevel
);
   localparam int unsigned N = mic_pkg::NumSrc;

   mic_pkg::mic_state_e stateQ;
   logic [23:0]            reqQ;
   logic                   mieQ;
   logic [4:0]             cntQ;
   logic [4:0]             selQ;
   logic [1:0]             selLvlQ;
   logic [1:0]             curLvlQ;
   logic [1:0]             lvlStackQ [mic_pkg::DepthMax];
   logic [2:0]             depthQ;
   logic [23:0]            eligible;
   logic [1:0]             lvl [N];
   logic                   winFound;
   logic [4:0]             winIdx;
   logic [1:0]             winLvl;
   logic                   accept;
   logic [4:0]             entryLast;
   logic [4:0]             returnLast;
   logic [4:0]             csrOfs;
   logic                   returnStart;

   // level decode and eligibility per source
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_src
         assign lvl[g] = priority_level_code[2*g+1] ? mic_pkg::LevelHigh :
                         (priority_level_code[2*g] ? mic_pkg::LevelMid : mic_pkg::LevelLow);
         assign eligible[g] = reqQ[g] && source_enable[g] && mieQ &&
                              (!priority_ctrl_on || curLvlQ == mic_pkg::LevelIdle ||
                               lvl[g] > curLvlQ);
      end
   endgenerate

   // arbitration: highest level, then lowest index (lowest vector address)
   always_comb begin
      winFound = 1'b0;
      winIdx   = 5'h0;
      winLvl   = mic_pkg::LevelLow;
      for (int i = 0; i < N; i++) begin
         if (eligible[i]) begin
            // strict compare keeps the earlier (lower) vector on ties
            if (!winFound || (priority_ctrl_on && lvl[i] > winLvl)) begin
               winFound = 1'b1;
               winIdx   = 5'(i);
               winLvl   = lvl[i];
            end
         end
      end
   end

   // only taken at an instruction boundary while idle; nmi/reset live elsewhere
   assign accept     = (stateQ == mic_pkg::MIC_IDLE) && instrBoundary && winFound &&
                       !return_from_irq_instr;
   assign entryLast  = expandedSpace ? 5'(mic_pkg::EntryCyclesX - 1)
                                     : 5'(mic_pkg::EntryCycles - 1);
   assign returnLast = expandedSpace ? 5'(mic_pkg::ReturnCyclesX - 1)
                                     : 5'(mic_pkg::ReturnCycles - 1);
   assign csrOfs     = expandedSpace ? 5'h3 : 5'h0;
   // start of the exit walk, as the sequencer takes it below
   assign returnStart = (stateQ == mic_pkg::MIC_IDLE) && instrBoundary &&
                        return_from_irq_instr;

   // sequencer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stateQ <= mic_pkg::MIC_IDLE;
         cntQ   <= 5'h0;
         selQ   <= 5'h0;
         selLvlQ <= mic_pkg::LevelLow;
      end else begin
         case (stateQ)
            mic_pkg::MIC_IDLE: begin
               cntQ <= 5'h0;
               if (accept) begin
                  stateQ  <= mic_pkg::MIC_ENTRY;
                  selQ    <= winIdx;
                  selLvlQ <= winLvl;
               end else if (instrBoundary && return_from_irq_instr) begin
                  stateQ <= mic_pkg::MIC_RETURN;
               end
            end
            mic_pkg::MIC_ENTRY: begin
               if (cntQ == entryLast) begin
                  stateQ <= mic_pkg::MIC_IDLE;
                  cntQ   <= 5'h0;
               end else begin
                  cntQ <= cntQ + 5'h1;
               end
            end
            mic_pkg::MIC_RETURN: begin
               if (cntQ == returnLast) begin
                  stateQ <= mic_pkg::MIC_IDLE;
                  cntQ   <= 5'h0;
               end else begin
                  cntQ <= cntQ + 5'h1;
               end
            end
            default: stateQ <= mic_pkg::MIC_IDLE;
         endcase
      end
   end

   // request flags; a new event wins over both software and entry clear
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reqQ <= 24'h000000;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (srcEvent[i]) begin
               reqQ[i] <= 1'b1;
            end else if (reqWrEn) begin
               reqQ[i] <= reqWrData[i];
            end else if (stateQ == mic_pkg::MIC_ENTRY && cntQ == mic_pkg::StepClearReq &&
                         selQ == 5'(i)) begin
               reqQ[i] <= 1'b0;
            end
         end
      end
   end

   // master enable; cleared at acceptance so nothing slips in during entry
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mieQ <= 1'b0;
      end else if (accept) begin
         mieQ <= 1'b0;
      end else if (stateQ == mic_pkg::MIC_RETURN && cntQ == returnLast) begin
         mieQ <= 1'b1;
      end else if (mieWrEn && stateQ == mic_pkg::MIC_IDLE) begin
         mieQ <= mieWrData;
      end
   end

   // in-service level stack; overflow beyond the depth drops the oldest save
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         curLvlQ <= mic_pkg::LevelIdle;
         depthQ  <= 3'h0;
         for (int k = 0; k < mic_pkg::DepthMax; k++) begin
            lvlStackQ[k] <= mic_pkg::LevelIdle;
         end
      end else if (accept) begin
         curLvlQ <= winLvl;
         lvlStackQ[0] <= curLvlQ;
         for (int k = 1; k < mic_pkg::DepthMax; k++) begin
            lvlStackQ[k] <= lvlStackQ[k-1];
         end
         if (depthQ != 3'(mic_pkg::DepthMax)) begin
            depthQ <= depthQ + 3'h1;
         end
      end else if (stateQ == mic_pkg::MIC_RETURN && cntQ == 5'h0) begin
         curLvlQ <= lvlStackQ[0];
         for (int k = 0; k < mic_pkg::DepthMax - 1; k++) begin
            lvlStackQ[k] <= lvlStackQ[k+1];
         end
         lvlStackQ[mic_pkg::DepthMax-1] <= mic_pkg::LevelIdle;
         if (depthQ != 3'h0) begin
            depthQ <= depthQ - 3'h1;
         end
      end
   end

   // save/restore strobes to the core: step 0 pc, 1 acc, 2 base, 3 status, 4 code seg
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         saveStrobe    <= 1'b0;
         saveStep      <= 3'h0;
         restoreStrobe <= 1'b0;
         restoreStep   <= 3'h0;
         pcLoad        <= 1'b0;
         pcVector      <= 16'h0000;
      end else begin
         saveStrobe    <= 1'b0;
         restoreStrobe <= 1'b0;
         pcLoad        <= 1'b0;
         if (stateQ == mic_pkg::MIC_ENTRY) begin
            // code segment first when expanded, then pc, acc, base, status two cycles apart
            if (expandedSpace && cntQ == mic_pkg::StepSaveCsr) begin
               saveStrobe <= 1'b1;
               saveStep   <= 3'h4;
            end else if (cntQ >= csrOfs && cntQ - csrOfs <= mic_pkg::StepSavePsw &&
                         !cntQ[0] == !csrOfs[0]) begin
               saveStrobe <= 1'b1;
               saveStep   <= 3'((cntQ - csrOfs) >> 1);
            end
            if (cntQ == entryLast) begin
               pcLoad   <= 1'b1;
               pcVector <= mic_pkg::VecTable[selQ];
            end
         end
         if (stateQ == mic_pkg::MIC_RETURN) begin
            // status, base, acc, pc, then code segment when expanded
            if (cntQ >= 5'h2 && !cntQ[0] && cntQ <= 5'h8 + (expandedSpace ? 5'h2 : 5'h0)) begin
               restoreStrobe <= 1'b1;
               // code segment comes last, after the pc
               if (cntQ == 5'hA) begin
                  restoreStep <= 3'h4;
               end else begin
                  restoreStep <= 3'h3 - 3'((cntQ - 5'h2) >> 1);
               end
            end
         end
      end
   end

   // status outputs
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reqFlags          <= 24'h000000;
         master_irq_enable <= 1'b0;
         entryBusy         <= 1'b0;
         returnBusy        <= 1'b0;
         inServiceLevel    <= mic_pkg::LevelIdle;
      end else begin
         reqFlags          <= reqQ;
         master_irq_enable <= mieQ;
         entryBusy         <= stateQ == mic_pkg::MIC_ENTRY;
         returnBusy        <= stateQ == mic_pkg::MIC_RETURN;
         inServiceLevel    <= curLvlQ;
      end
   end

   // entry and return walks as the core sees them, one step per strobe
   sequence seqSaveOrder;
      saveStrobe && saveStep == 3'h0 ##2 saveStrobe && saveStep == 3'h1
      ##2 saveStrobe && saveStep == 3'h2 ##2 saveStrobe && saveStep == 3'h3;
   endsequence

   sequence seqRestoreOrder;
      restoreStrobe && restoreStep == 3'h3 ##2 restoreStrobe && restoreStep == 3'h2
      ##2 restoreStrobe && restoreStep == 3'h1 ##2 restoreStrobe && restoreStep == 3'h0;
   endsequence

   // pcLoad is registered, so it is sampled one edge after the last entry cycle
   chk_entry_length: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept && !expandedSpace |-> ##15 pcLoad) else $error("entry length wrong");
   chk_entry_long: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept && expandedSpace |-> ##18 pcLoad) else $error("long entry length wrong");
   chk_save_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept && !expandedSpace |-> ##2 seqSaveOrder) else $error("save order wrong");
   chk_save_long: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept && expandedSpace |-> ##2 (saveStrobe && saveStep == 3'h4) ##3 seqSaveOrder)
      else $error("long save order wrong");
   chk_restore_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
      returnStart |-> ##4 seqRestoreOrder) else $error("restore order wrong");
   chk_restore_csr: assert property (@(posedge sys_clk) disable iff (sys_rst)
      returnStart && expandedSpace |-> ##12 (restoreStrobe && restoreStep == 3'h4))
      else $error("code segment not restored");
   chk_pc_vector: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pcLoad |-> pcVector == mic_pkg::VecTable[selQ]) else $error("wrong vector");
   chk_nest_higher: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept && priority_ctrl_on && curLvlQ != mic_pkg::LevelIdle |-> winLvl > curLvlQ)
      else $error("nested at equal or lower level");
   chk_enabled_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept |-> source_enable[winIdx] && reqQ[winIdx])
      else $error("disabled or idle source taken");
   chk_stack_depth: assert property (@(posedge sys_clk) disable iff (sys_rst)
      depthQ <= 3'(mic_pkg::DepthMax)) else $error("level stack depth out of range");
   chk_return_mie_long: assert property (@(posedge sys_clk) disable iff (sys_rst)
      returnStart && expandedSpace |-> ##15 mieQ)
      else $error("long return did not set enable");
   chk_mie_cleared: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept |=> !mieQ) else $error("enable not cleared on entry");
   chk_lowest_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept && !priority_ctrl_on |-> (eligible & ((24'h1 << winIdx) - 24'h1)) == 24'h0)
      else $error("lower vector skipped");
   chk_blocked_mie: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !mieQ |-> eligible == 24'h0) else $error("source eligible with enable clear");
   chk_level_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept && priority_ctrl_on |=> ##1 (curLvlQ == $past(winLvl, 2)))
      else $error("level not raised");
   chk_return_mie: assert property (@(posedge sys_clk) disable iff (sys_rst)
      returnStart && !expandedSpace
      |-> ##13 mieQ) else $error("return did not set enable");
   // a fresh event in the clearing cycle wins, so it excuses a set flag
   chk_clear_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
      accept |-> ##10 (reqQ[selQ] == 1'b0 || $past(srcEvent[selQ])))
      else $error("serviced flag not cleared");
endmodule : mic_irq_ctrl
`default_nettype wire

// ==== dv/mic_core_model.sv ====
// behavioural model of the cpu core: instruction boundaries and handler returns
`timescale 1ns/100ps
`default_nettype none
module mic_core_model (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic pcLoad,
   input  wire logic returnBusy,
   output logic      instrBoundary,
   output logic      return_from_irq_instr
);
   // handler length varies from prompt to slow, boundaries come irregularly
   initial begin
      int d;
      instrBoundary = 1'b0;
      return_from_irq_instr = 1'b0;
      forever begin
         @(negedge sys_clk);
         instrBoundary = !sys_rst && ($urandom() % 4 != 0);
         if (pcLoad === 1'b1) begin
            d = $urandom() % 30;
            repeat (d) @(negedge sys_clk);
            instrBoundary = 1'b1;
            return_from_irq_instr = 1'b1;
            // request held until the return is seen under way
            while (returnBusy !== 1'b1) @(negedge sys_clk);
            return_from_irq_instr = 1'b0;
         end
      end
   end
endmodule // mic_core_model
`default_nettype wire

// ==== dv/test_maskable_interrupt_controller.sv ====
// self-checking bench of the maskable interrupt controller
`timescale 1ns/100ps
`default_nettype none
module test_maskable_interrupt_controller;
   localparam logic [15:0] VecExp [24] = '{
      16'h000A, 16'h000C, 16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h001E, 16'h0020,
      16'h0026, 16'h0028, 16'h002A, 16'h002C, 16'h0036, 16'h0038, 16'h003A, 16'h003E,
      16'h0042, 16'h0044, 16'h0048, 16'h006A, 16'h006C, 16'h006E, 16'h0070, 16'h0072};
   logic        sys_clk, sys_rst, priority_ctrl_on, expandedSpace, reqWrEn, mieWrEn;
   logic        mieWrData, instrBoundary, return_from_irq_instr, master_irq_enable;
   logic        entryBusy, returnBusy, saveStrobe, restoreStrobe, pcLoad;
   logic [23:0] srcEvent, source_enable, reqWrData, reqFlags, pend;
   logic [47:0] priority_level_code;
   logic [15:0] pcVector;
   logic [2:0]  saveStep, restoreStep;
   logic [1:0]  inServiceLevel;
   int          errorCnt = 0, nTests = 0, t;

   mic_irq_ctrl mic_irq_ctrl_i (.sys_clk, .sys_rst, .srcEvent, .source_enable,
      .priority_level_code, .priority_ctrl_on, .expandedSpace, .reqWrEn, .reqWrData,
      .mieWrEn, .mieWrData, .instrBoundary, .return_from_irq_instr, .reqFlags,
      .master_irq_enable, .entryBusy, .returnBusy, .saveStep, .saveStrobe,
      .restoreStrobe, .restoreStep, .pcLoad, .pcVector, .inServiceLevel);
   mic_core_model mic_core_model_i (.sys_clk, .sys_rst, .pcLoad, .returnBusy,
      .instrBoundary, .return_from_irq_instr);

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         errorCnt++;
      end
   endtask

   task automatic giveVerdict();
      if (errorCnt == 0 && nTests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic int lvl(input int i);
      return priority_ctrl_on ? (priority_level_code[2*i+1] ? 2 : int'(priority_level_code[2*i])) : 0;
   endfunction

   // scan downwards so that a tie leaves the lowest index
   function automatic int pick(input logic [23:0] m);
      int b = -1;
      for (int i = 23; i >= 0; i--)
         if (m[i] && (b < 0 || lvl(i) >= lvl(b))) b = i;
      return b;
   endfunction

   // one entry, handler and return, compared with the model
   task automatic serve(input int idx);
      int n = 0;
      int w = 0;
      logic [14:0] seq = '0;
      while (entryBusy !== 1'b1 && w < 300) begin
         @(negedge sys_clk);
         w++;
      end
      while (pcLoad !== 1'b1 && n < 40) begin
         if (saveStrobe === 1'b1) seq = {seq[11:0], saveStep};
         @(negedge sys_clk);
         n++;
      end
      check(pcVector, VecExp[idx]);
      check(n, expandedSpace ? 16 : 13);
      check(seq, expandedSpace ? 15'h4053 : 15'h0053);
      check(reqFlags, pend);
      check(master_irq_enable, 1'b0);
      if (priority_ctrl_on) check(inServiceLevel, lvl(idx));
      seq = '0;
      w = 0;
      n = 0;
      while (returnBusy !== 1'b1 && w < 100) begin
         @(negedge sys_clk);
         w++;
      end
      while (returnBusy === 1'b1 && n < 40) begin
         if (restoreStrobe === 1'b1) seq = {seq[11:0], restoreStep};
         @(negedge sys_clk);
         n++;
      end
      check(n, expandedSpace ? 14 : 12);
      check(seq, expandedSpace ? 15'h3444 : 15'h0688);
      check(master_irq_enable, 1'b1);
   endtask

   // events in one cycle, served in model order, then the disabled ones enabled
   task automatic round(input logic [23:0] ev, input logic [23:0] en);
      int idx;
      source_enable = en;
      priority_level_code = 48'({$urandom(), $urandom()});
      srcEvent = ev;
      pend = pend | ev;
      @(negedge sys_clk);
      srcEvent = '0;
      for (int k = 0; k < 2; k++) begin
         while ((pend & source_enable) != 0) begin
            idx = pick(pend & source_enable);
            pend[idx] = 1'b0;
            serve(idx);
         end
         check(reqFlags, pend);
         source_enable = '1;
      end
   endtask

   initial begin
      void'($urandom(32'h28F9));
      {srcEvent, source_enable, priority_level_code, priority_ctrl_on, expandedSpace,
       reqWrEn, reqWrData, mieWrEn, mieWrData, pend} = '0;
      sys_rst = 1'b1;
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      @(negedge sys_clk);
      check(inServiceLevel, 2'h3);
      // master enable still low after reset: request must wait
      source_enable = 24'h000001;
      srcEvent = 24'h000001;
      @(negedge sys_clk);
      srcEvent = '0;
      repeat (30) @(negedge sys_clk);
      check({master_irq_enable, entryBusy, reqFlags}, 26'h0000001);
      mieWrData = 1'b1;
      mieWrEn = 1'b1;
      @(negedge sys_clk);
      mieWrEn = 1'b0;
      serve(0);
      for (t = 0; t < 24; t++) begin
         expandedSpace = t[0];
         round(24'h1 << t, 24'h1 << t);
      end
      for (t = 0; t < 8; t++) begin
         priority_ctrl_on = t[0];
         expandedSpace = t[1];
         round(24'($urandom()), 24'($urandom()));
      end
      source_enable = '0;
      reqWrData = 24'($urandom());
      reqWrEn = 1'b1;
      @(negedge sys_clk);
      reqWrEn = 1'b0;
      @(negedge sys_clk);
      check(reqFlags, reqWrData);
      giveVerdict();
   end

   // all rounds together need well under a third of this span
   initial begin
      repeat (40000) @(posedge sys_clk);
      errorCnt++;
      giveVerdict();
   end
endmodule // test_maskable_interrupt_controller
`default_nettype wire
